// >>> dag_pkg.sv
// constants, field layouts and types of the data address generator
package dag_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned HALF_W = 16;

    // register byte offsets
    localparam logic [5:0] OFS_GPR_BASE = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h20;
    localparam logic [5:0] OFS_MODULO = 6'h24;
    localparam logic [5:0] OFS_COMMAND = 6'h28;
    localparam logic [5:0] OFS_X_ADDR = 6'h2C;
    localparam logic [5:0] OFS_Y_ADDR = 6'h30;
    localparam logic [5:0] OFS_MAIN_ADDR = 6'h34;

    // general register numbers
    localparam logic [3:0] GPR_FIRST = 4'h2;
    localparam logic [3:0] GPR_LAST = 4'h9;
    localparam logic [3:0] REG_X_BASE = 4'h4;
    localparam logic [3:0] REG_Y_BASE = 4'h6;
    localparam logic [3:0] REG_X_INDEX = 4'h8;
    localparam logic [3:0] REG_Y_INDEX = 4'h9;
    localparam logic [3:0] REG_S_BASE = 4'h2;
    localparam logic [3:0] REG_S_INDEX = 4'h8;

    // steps and field positions
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam int unsigned SR_DMX_BIT = 0;
    localparam int unsigned SR_DMY_BIT = 1;
    localparam int unsigned CMD_W = 12;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] STATUS_RESET = 2'h0;

    typedef enum logic [1:0] {
        UPD_NONE = 2'h0,
        UPD_INDEX = 2'h1,
        UPD_INC = 2'h2,
        UPD_DEC = 2'h3
    } update_t;

    typedef enum logic [1:0] {
        KIND_IDLE = 2'h0,
        KIND_DUAL = 2'h1,
        KIND_SINGLE_WORD = 2'h2,
        KIND_SINGLE_LONG = 2'h3
    } kind_t;

    // command word, kind in bits 1:0
    typedef struct packed {
        update_t s_mode;
        logic [1:0] s_sel;
        update_t y_mode;
        update_t x_mode;
        logic y_sel;
        logic x_sel;
        kind_t kind;
    } cmd_t;

    // modulo bounds register, end in upper half
    typedef struct packed {
        logic [15:0] modulo_end;
        logic [15:0] modulo_start;
    } bounds_t;

    // byte-enable merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return r;
    endfunction
endpackage

// >>> pointer_step.sv
// dual transfer pointer update with optional modulo wrap
module pointer_step (
    input wire logic [31:0] pointer,
    input wire logic [31:0] index,
    input wire dag_pkg::update_t update,
    input wire logic modulo_on,
    input wire logic low_half_only,
    input wire dag_pkg::bounds_t bounds,
    output logic [31:0] next_pointer
);
    logic [31:0] addend;
    logic [31:0] sum_full;
    logic [31:0] plain;
    logic [31:0] wrapped;
    logic wrap;

    // increment adds two, index add adds the matching index
    assign addend = (update == dag_pkg::UPD_INDEX) ? index
                                                   : dag_pkg::STEP_WORD;
    assign sum_full = pointer + addend;
    // y pointer keeps its upper half
    assign plain = low_half_only ? {pointer[31:16], sum_full[15:0]}
                                 : sum_full;
    // only an exact match wraps; overshoot keeps the sum
    assign wrap = modulo_on && (update != dag_pkg::UPD_NONE)
                  && (pointer[15:0] == bounds.modulo_end);
    assign wrapped = {pointer[31:16], bounds.modulo_start[15:1],
                      pointer[0]};
    assign next_pointer = (update == dag_pkg::UPD_NONE) ? pointer
                        : wrap ? wrapped : plain;
endmodule // pointer_step

// >>> single_step.sv
// single transfer access address and pointer update
module single_step (
    input wire logic [31:0] pointer,
    input wire logic [31:0] index,
    input wire dag_pkg::update_t update,
    input wire logic long_move,
    output logic [31:0] access_addr,
    output logic [31:0] next_pointer
);
    logic [31:0] step;
    logic [31:0] reduced;

    assign step = long_move ? dag_pkg::STEP_LONG : dag_pkg::STEP_WORD;
    assign reduced = pointer - step;
    // decrement is pre-update, the rest post-update
    assign access_addr = (update == dag_pkg::UPD_DEC) ? reduced
                                                      : pointer;
    always_comb begin
        unique case (update)
            dag_pkg::UPD_NONE: next_pointer = pointer;
            dag_pkg::UPD_INDEX: next_pointer = pointer + index;
            dag_pkg::UPD_INC: next_pointer = pointer + step;
            dag_pkg::UPD_DEC: next_pointer = reduced;
        endcase
    end
endmodule // single_step

// >>> dsp_data_address_generator.sv
// data address generator with its register file and avalon slave
//
// Added by the designer: the register offsets and the Avalon-MM register port.
module dsp_data_address_generator (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [15:0] x_address_bus,
    output logic [15:0] y_address_bus,
    output logic [31:0] main_address_bus,
    output logic xy_access,
    output logic single_access,
    output logic single_long
);
    logic [31:0] gpr [dag_pkg::GPR_FIRST:dag_pkg::GPR_LAST];
    logic [1:0] status_reg;
    dag_pkg::bounds_t modulo_bounds_reg;
    dag_pkg::cmd_t cmd;
    logic exec_valid;

    // bus handshake: accept on second cycle of a request
    logic request;
    logic accept;
    logic write_accept;
    logic [3:0] gpr_sel;
    logic gpr_hit;
    logic [31:0] next_readdata;

    assign request = read | write;
    assign accept = request & ~waitrequest;
    assign write_accept = write & ~waitrequest;
    assign gpr_hit = (address < dag_pkg::OFS_STATUS);
    assign gpr_sel = address[5:2] + dag_pkg::GPR_FIRST;

    // execute stage decode
    logic dual;
    logic single;
    logic x_mod;
    logic y_mod;
    logic [3:0] x_reg;
    logic [3:0] y_reg;
    logic [3:0] s_reg;
    logic [31:0] x_ptr;
    logic [31:0] y_ptr;
    logic [31:0] s_ptr;
    logic [31:0] next_x;
    logic [31:0] next_y;
    logic [31:0] next_s;
    logic [31:0] s_addr;

    assign dual = exec_valid && (cmd.kind == dag_pkg::KIND_DUAL);
    assign single = exec_valid && ((cmd.kind == dag_pkg::KIND_SINGLE_WORD)
                    || (cmd.kind == dag_pkg::KIND_SINGLE_LONG));
    assign x_reg = dag_pkg::REG_X_BASE + {3'h0, cmd.x_sel};
    assign y_reg = dag_pkg::REG_Y_BASE + {3'h0, cmd.y_sel};
    assign s_reg = dag_pkg::REG_S_BASE + {2'h0, cmd.s_sel};
    assign x_ptr = gpr[x_reg];
    assign y_ptr = gpr[y_reg];
    assign s_ptr = gpr[s_reg];
    // y enable wins when both are set
    assign y_mod = status_reg[dag_pkg::SR_DMY_BIT];
    assign x_mod = status_reg[dag_pkg::SR_DMX_BIT] & ~y_mod;

    pointer_step x_step (
        .pointer(x_ptr),
        .index(gpr[dag_pkg::REG_X_INDEX]),
        .update(cmd.x_mode),
        .modulo_on(x_mod),
        .low_half_only(1'b0),
        .bounds(modulo_bounds_reg),
        .next_pointer(next_x)
    );

    pointer_step y_step (
        .pointer(y_ptr),
        .index(gpr[dag_pkg::REG_Y_INDEX]),
        .update(cmd.y_mode),
        .modulo_on(y_mod),
        .low_half_only(1'b1),
        .bounds(modulo_bounds_reg),
        .next_pointer(next_y)
    );

    // single path never sees modulo state
    single_step s_step (
        .pointer(s_ptr),
        .index(gpr[dag_pkg::REG_S_INDEX]),
        .update(cmd.s_mode),
        .long_move(cmd.kind == dag_pkg::KIND_SINGLE_LONG),
        .access_addr(s_addr),
        .next_pointer(next_s)
    );

    // read multiplexer
    always_comb begin
        next_readdata = dag_pkg::RESET_WORD;
        if (gpr_hit) begin
            next_readdata = gpr[gpr_sel];
        end else begin
            unique case (address)
                dag_pkg::OFS_STATUS: next_readdata = {30'h0, status_reg};
                dag_pkg::OFS_MODULO: next_readdata = modulo_bounds_reg;
                dag_pkg::OFS_COMMAND:
                    next_readdata = {20'h0, cmd};
                dag_pkg::OFS_X_ADDR: next_readdata = {16'h0, x_address_bus};
                dag_pkg::OFS_Y_ADDR: next_readdata = {16'h0, y_address_bus};
                dag_pkg::OFS_MAIN_ADDR: next_readdata = main_address_bus;
                default: next_readdata = dag_pkg::RESET_WORD;
            endcase
        end
    end

    // wait state and read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= dag_pkg::RESET_WORD;
        end else begin
            waitrequest <= ~(request & waitrequest);
            if (read & waitrequest) begin
                readdata <= next_readdata;
            end
        end
    end

    // general registers: bus writes, else execute write-back
    genvar g;
    generate
        for (g = dag_pkg::GPR_FIRST; g <= dag_pkg::GPR_LAST; g++) begin : gen_gpr
            logic bus_wr;
            assign bus_wr = write_accept && gpr_hit && (gpr_sel == 4'(g));
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    gpr[g] <= dag_pkg::RESET_WORD;
                end else if (bus_wr) begin
                    gpr[g] <= dag_pkg::merge(gpr[g], writedata, byteenable);
                end else if (dual && (x_reg == 4'(g))) begin
                    gpr[g] <= next_x;
                end else if (dual && (y_reg == 4'(g))) begin
                    gpr[g] <= next_y;
                end else if (single && (s_reg == 4'(g))) begin
                    gpr[g] <= next_s;
                end
            end
        end
    endgenerate

    // control registers and command launch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_reg <= dag_pkg::STATUS_RESET;
            modulo_bounds_reg <= dag_pkg::RESET_WORD;
            cmd <= dag_pkg::CMD_W'(0);
            exec_valid <= 1'b0;
        end else begin
            exec_valid <= write_accept && (address == dag_pkg::OFS_COMMAND);
            if (write_accept && (address == dag_pkg::OFS_STATUS)) begin
                status_reg <= 2'(dag_pkg::merge(32'(status_reg), writedata,
                                                byteenable));
            end
            if (write_accept && (address == dag_pkg::OFS_MODULO)) begin
                modulo_bounds_reg <= dag_pkg::merge(modulo_bounds_reg,
                                                    writedata, byteenable);
            end
            if (write_accept && (address == dag_pkg::OFS_COMMAND)) begin
                cmd <= dag_pkg::CMD_W'(dag_pkg::merge(32'(cmd), writedata,
                                                      byteenable));
            end
        end
    end

    // address buses from the execute stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            x_address_bus <= 16'h0000;
            y_address_bus <= 16'h0000;
            main_address_bus <= dag_pkg::RESET_WORD;
            xy_access <= 1'b0;
            single_access <= 1'b0;
            single_long <= 1'b0;
        end else begin
            xy_access <= dual;
            single_access <= single;
            if (dual) begin
                x_address_bus <= {x_ptr[15:1], 1'b0};
                y_address_bus <= {y_ptr[15:1], 1'b0};
            end
            if (single) begin
                main_address_bus <= s_addr;
                single_long <= (cmd.kind == dag_pkg::KIND_SINGLE_LONG);
            end
        end
    end
endmodule // dsp_data_address_generator

// >>> dag_monitor.sv
// concurrent checks on the address generator ports
module dag_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [15:0] x_address_bus,
    input wire logic [15:0] y_address_bus,
    input wire logic [31:0] main_address_bus,
    input wire logic xy_access,
    input wire logic single_access,
    input wire logic single_long
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // accepted full-word command write
    wire cmd_go = write && !waitrequest && byteenable == 4'hF
        && address == dag_pkg::OFS_COMMAND;
    AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    AST_WAIT_BOUND: assert property ((read || write) && waitrequest
        |-> ##[1:2] !waitrequest) else $error("request not answered");
    AST_IDLE_WAIT: assert property (!read && !write |-> waitrequest)
        else $error("waitrequest low without request");
    // command latched at the accepting edge, pulse launched one edge later
    AST_XY_START: assert property (cmd_go && writedata[1:0] == 2'h1
        |-> ##2 xy_access && !single_access) else $error("dual not issued");
    AST_S_START: assert property (cmd_go && writedata[1]
        |-> ##2 single_access && single_long == $past(writedata[0], 2))
        else $error("single not issued");
    AST_XY_CAUSE: assert property (xy_access
        |-> $past(cmd_go, 2) && $past(writedata[1:0], 2) == 2'h1)
        else $error("dual pulse without command");
    AST_XY_HOLD: assert property (!xy_access
        |-> $stable(x_address_bus) && $stable(y_address_bus))
        else $error("xy buses moved");
    AST_MAIN_HOLD: assert property (!single_access
        |-> $stable(main_address_bus) && $stable(single_long))
        else $error("main bus moved");
    AST_BIT0: assert property (!x_address_bus[0] && !y_address_bus[0])
        else $error("xy bus bit 0 set");
    AST_PULSE_ONE: assert property (xy_access || single_access
        |=> !xy_access && !single_access) else $error("pulse too long");
endmodule // dag_monitor

bind dsp_data_address_generator dag_monitor i_mon (.clk(clk),
    .reset(reset), .address(address), .byteenable(byteenable),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .x_address_bus(x_address_bus), .y_address_bus(y_address_bus),
    .main_address_bus(main_address_bus), .xy_access(xy_access),
    .single_access(single_access), .single_long(single_long));

// >>> mem_side_model.sv
// memory side model counting presented accesses
module mem_side_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic xy_access,
    input wire logic single_access,
    output int xy_count,
    output int single_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // memories take one access per presentation pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            xy_count <= 0;
            single_count <= 0;
        end else begin
            xy_count <= xy_count + int'(xy_access);
            single_count <= single_count + int'(single_access);
        end
    end
endmodule // mem_side_model

// >>> test_dsp_data_address_generator.sv
// self-checking bench of the data address generator
module test_dsp_data_address_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, read, write, waitrequest;
    logic xy_access, single_access, single_long;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, main_address_bus, q, bnd, r;
    logic [15:0] x_address_bus, y_address_bus;
    logic [31:0] gpr [2:9];
    int num_errors, cmp_count, seed, n_xy, n_s, xy_count, single_count;

    dsp_data_address_generator i_dut (.clk(clk), .reset(reset),
        .address(address), .byteenable(byteenable), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .x_address_bus(x_address_bus),
        .y_address_bus(y_address_bus), .xy_access(xy_access),
        .main_address_bus(main_address_bus),
        .single_access(single_access), .single_long(single_long));
    mem_side_model i_mem (.clk(clk), .reset(reset), .xy_access(xy_access),
        .single_access(single_access), .xy_count(xy_count),
        .single_count(single_count));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic end_sim;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic setr(input int n, input logic [31:0] v);
        bus(1'b1, 6'((n - 2) * 4), v);
        gpr[n] = v;
    endtask

    task automatic getr(input int n);
        bus(1'b0, 6'((n - 2) * 4), 32'h0);
        chk(q, gpr[n]);
    endtask

    // expected dual pointer update
    function automatic logic [31:0] dual_nx(input logic [31:0] p, i,
        input logic [1:0] m, input logic mo, lo);
        logic [31:0] s, v;
        s = (m == 2'h1) ? i : 32'h2;
        v = lo ? {p[31:16], p[15:0] + s[15:0]} : p + s;
        if (m == 2'h0) v = p;
        else if (mo && p[15:0] == bnd[31:16]) v = {p[31:16], bnd[15:1], p[0]};
        return v;
    endfunction

    // pointer value with bit 0 clear, often sitting on the end bound
    function automatic logic [31:0] rv();
        logic [31:0] v;
        v = $random(seed) & 32'hFFFF_FFFE;
        if (v[20]) v[15:0] = bnd[31:16];
        return v;
    endfunction

    task automatic dual(input logic xs, ys, input logic [1:0] xm, ym, sr);
        logic [31:0] xp, yp;
        xp = gpr[4 + xs];
        yp = gpr[6 + ys];
        bus(1'b1, dag_pkg::OFS_MODULO, bnd);
        bus(1'b1, dag_pkg::OFS_STATUS, {30'h0, sr});
        bus(1'b1, dag_pkg::OFS_COMMAND, {24'h0, ym, xm, ys, xs, 2'h1});
        n_xy++;
        @(posedge clk);
        #1;
        chk({31'h0, xy_access}, 32'h1);
        chk({x_address_bus, y_address_bus}, {xp[15:1], 1'b0, yp[15:1], 1'b0});
        gpr[4 + xs] = dual_nx(xp, gpr[8], xm, sr == 2'h1, 1'b0);
        gpr[6 + ys] = dual_nx(yp, gpr[9], ym, sr[1], 1'b1);
        getr(4 + xs);
        getr(6 + ys);
    endtask

    task automatic single(input logic lg, input logic [1:0] sel, m);
        logic [31:0] p, s, a;
        p = gpr[2 + sel];
        s = (m == 2'h1) ? gpr[8] : (m == 2'h0) ? 32'h0 : (lg ? 32'h4 : 32'h2);
        a = (m == 2'h3) ? p - s : p;
        gpr[2 + sel] = (m == 2'h3) ? a : p + s;
        // kind field: single word or single long
        bus(1'b1, dag_pkg::OFS_COMMAND, {20'h0, m, sel, 6'h0, 1'b1, lg});
        n_s++;
        @(posedge clk);
        #1;
        chk({30'h0, single_access, single_long}, {30'h0, 1'b1, lg});
        chk(main_address_bus, a);
        getr(2 + sel);
    endtask

    // main sequence
    initial begin
        seed = 49559;
        {reset, read, write, address, byteenable} = {3'h4, 6'h0, 4'hF};
        {writedata, bnd, num_errors, cmp_count, n_xy, n_s} = '0;
        for (int n = 2; n < 10; n++) gpr[n] = 32'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        getr(2);
        getr(9);
        // unmapped place reads zero and ignores writes
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
        bus(1'b0, 6'h3C, 32'h0);
        chk(q, 32'h0);
        // increment walk onto the end bound then back to start
        bnd = 32'hE00C_E008;
        setr(4, 32'h1000_E008);
        repeat (3) dual(1'b0, 1'b0, 2'h2, 2'h0, 2'h1);
        chk(gpr[4], 32'h1000_E008);
        // random pointers, modes and modulo settings
        for (int k = 0; k < 50; k++) begin
            bnd = $random(seed) & 32'hFFFE_FFFE;
            for (int n = 2; n < 10; n++) setr(n, rv());
            r = $random(seed);
            dual(r[0], r[1], r[3:2], r[5:4], r[7:6]);
            single(r[8], r[10:9], r[12:11]);
        end
        chk(32'(xy_count), 32'(n_xy));
        chk(32'(single_count), 32'(n_s));
        end_sim;
    end

    // watchdog
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
endmodule // test_dsp_data_address_generator
